// ### rtl/exc_entry_defines.vh
`ifndef EXC_ENTRY_DEFINES_VH
`define EXC_ENTRY_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_MATCH_EN    8'h04
`define OFS_FAST_VEC    8'h08
`define OFS_SAVED_FLAGS 8'h0C
`define OFS_SAVED_PC    8'h10
`define OFS_STATUS      8'h14
`define OFS_MATCH_BASE  8'h20
`define OFS_MATCH_LAST  8'h3C

// ----------------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_FAST_SEL   0
`define CTRL_DMA_SEL    1
`define CTRL_RST        2'h0
`define MATCH_EN_RST    8'h00
`define FAST_VEC_RST    24'h000000
`define MATCH_ADDR_RST  24'h000000

// ----------------------------------------------------------------------------
// flag register fields
// ----------------------------------------------------------------------------
`define FLAG_O          2
`define FLAG_I          6
`define FLAG_U          7
`define FLAG_IPL_HI     14
`define FLAG_IPL_LO     12
`define LEVEL_FAST      3'h7

// ----------------------------------------------------------------------------
// instruction codes presented by the core
// ----------------------------------------------------------------------------
`define OP_NONE         3'h0
`define OP_UNDEF        3'h1
`define OP_BREAK        3'h2
`define OP_INTO         3'h3
`define OP_INT          3'h4
`define OP_FAST_RET     3'h5
`define OP_DBG_BREAK    3'h6

// ----------------------------------------------------------------------------
// entry causes
// ----------------------------------------------------------------------------
`define CAUSE_NONE      4'h0
`define CAUSE_NMI       4'h1
`define CAUSE_WDT       4'h2
`define CAUSE_OSC       4'h3
`define CAUSE_MATCH     4'h4
`define CAUSE_UNDEF     4'h5
`define CAUSE_BREAK     4'h6
`define CAUSE_OVF       4'h7
`define CAUSE_INT       4'h8
`define CAUSE_PER       4'h9
`define CAUSE_FAST      4'hA
`define CAUSE_FRET      4'hB

// ----------------------------------------------------------------------------
// fixed vector addresses
// ----------------------------------------------------------------------------
`define VEC_UNDEF       24'hFFFFDC
`define VEC_OVF         24'hFFFFE0
`define VEC_BREAK       24'hFFFFE4
`define VEC_MATCH       24'hFFFFE8
`define VEC_WDT         24'hFFFFF0
`define VEC_NMI         24'hFFFFF8

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FAST_ENTRY_CYC  3'h5
`define FAST_RET_CYC    3'h3
`define SW_NUM_SPLIT    6'h20

`endif

// ### rtl/addr_match_cmp.v
module addr_match_cmp (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [23:0] wr_addr,
  input  wire        enable,
  input  wire        instr_valid,
  input  wire [23:0] instr_addr,
  output wire [23:0] match_addr,
  output wire        hit
);
`include "exc_entry_defines.vh"

  reg [23:0] match_address_reg_r;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      match_address_reg_r <= `MATCH_ADDR_RST;
    end else if (wr_en) begin
      match_address_reg_r <= wr_addr;
    end
  end

  assign match_addr = match_address_reg_r;
  // only first-byte addresses are presented; table data never is
  assign hit        = enable & instr_valid & (instr_addr == match_address_reg_r);

endmodule // addr_match_cmp

// ### rtl/interrupt_entry.v
// Notes on behaviour
// - maskable requests need the I flag set and a level above the current level.
// - non-maskable sources ignore the I flag and have a fixed order.
// - undefined-opcode trap and break instructions raise their own non-maskable traps.
// - overflow trap instruction raises an interrupt only when the O flag is 1.
// - software vector call accepts numbers 0 to 63 via the relocatable table.
// - numbers 8-48, 52-54 and 57 share entries with peripheral requests.
// - vector call pushes flags and PC, then loads PC from the vector.
// - numbers 0-31 clear the U flag; 32-63 keep the current stack.
// - peripheral acknowledge saves flags and always clears the U flag.
// - a high-to-low edge on the NMI pin raises the NMI interrupt.
// - watchdog underflow raises a non-maskable interrupt.
// - oscillation stop detection raises a non-maskable interrupt.
// - eight enabled comparators raise an interrupt just before a matching instruction.
// - only an instruction's first byte address can trigger a match.
// - peripheral requests are maskable and dispatch through shared relocatable entries.
// - fast entry takes five cycles, fast return three.
// - with the fast select bit set, level 7 requests become the fast interrupt.
// - fast entry copies flags and PC to save registers, then uses the fast vector.
// - fast return restores flags and PC from the save registers.
// - fast save registers are shared with transfer channels two and three.
//
// Chosen here: the placing of the registers and strobed register access.
module interrupt_entry (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  input  wire        instr_valid,
  input  wire [23:0] instr_addr,
  input  wire [2:0]  instr_op,
  input  wire [5:0]  int_num,
  input  wire [15:0] flag_register,
  input  wire [23:0] pc_cur,
  input  wire [23:0] intb_base,
  input  wire        per_req,
  input  wire [2:0]  per_level,
  input  wire [5:0]  per_num,
  output wire        per_ack,
  input  wire        nmi_pin_b,
  input  wire        wdt_underflow,
  input  wire        osc_stop_det,
  output wire        core_hold,
  output wire        push_req,
  output wire [15:0] push_flags,
  output wire [23:0] push_pc,
  output wire        vec_fetch,
  output wire [23:0] vec_addr,
  output wire        pc_load,
  output wire [23:0] pc_value,
  output wire        flag_load,
  output wire [15:0] flag_value,
  output wire        fast_active,
  output wire        xfer_ch23_blocked
);
`include "exc_entry_defines.vh"

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PUSH = 5'h02;
  localparam [4:0] ST_LOAD = 5'h04;
  localparam [4:0] ST_FENT = 5'h08;
  localparam [4:0] ST_FRET = 5'h10;

  reg  [4:0]  st_r;
  reg  [4:0]  st_nxt;
  reg  [2:0]  cnt_r;
  reg  [1:0]  ctrl_r;
  reg  [7:0]  match_enable_reg_r;
  reg  [23:0] fast_vector_reg_r;
  reg  [15:0] saved_flags_reg_r;
  reg  [23:0] saved_pc_reg_r;
  reg         nmi_prev_r;
  reg         nmi_pend_r;
  reg         wdt_pend_r;
  reg         osc_pend_r;
  reg         match_arm_r;
  reg         fast_active_r;
  reg  [15:0] push_flags_r;
  reg  [23:0] push_pc_r;
  reg  [23:0] vec_addr_r;
  reg  [23:0] pc_value_r;
  reg  [15:0] flag_value_r;
  reg  [3:0]  last_cause_r;
  reg  [31:0] rdata_r;

  reg         take;
  reg  [3:0]  cause;
  reg  [23:0] sel_vec;
  reg         clr_u;
  reg         ack;
  reg  [31:0] rd_mux;

  wire [7:0]  hit_vec;
  wire [23:0] match_addr [0:7];
  wire [2:0]  ipl      = flag_register[`FLAG_IPL_HI:`FLAG_IPL_LO];
  wire        nmi_fall = nmi_prev_r & ~nmi_pin_b;
  wire        match_hit = match_arm_r & (|hit_vec);
  wire        idle     = (st_r == ST_IDLE);
  wire        wr_match = reg_wr & (reg_addr >= `OFS_MATCH_BASE) & (reg_addr <= `OFS_MATCH_LAST);
  wire [7:0]  wr_sel   = {7'h00, wr_match & (reg_addr[1:0] == 2'b00)} << reg_addr[4:2];
  wire        fast_sel = ctrl_r[`CTRL_FAST_SEL];

  // --------------------------------------------------------------------------
  // address match comparators
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_match
      addr_match_cmp u_cmp (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .wr_en       (wr_sel[gi]),
        .wr_addr     (reg_wdata[23:0]),
        .enable      (match_enable_reg_r[gi]),
        .instr_valid (instr_valid),
        .instr_addr  (instr_addr),
        .match_addr  (match_addr[gi]),
        .hit         (hit_vec[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // source selection at an instruction boundary
  // --------------------------------------------------------------------------
  always @* begin
    take    = 1'b0;
    cause   = `CAUSE_NONE;
    sel_vec = 24'h000000;
    clr_u   = 1'b1;
    ack     = 1'b0;
    if (idle && instr_valid) begin
      // fixed order; only the peripheral request branch checks the I flag
      if (nmi_pend_r) begin
        take    = 1'b1;
        cause   = `CAUSE_NMI;
        sel_vec = `VEC_NMI;
      end else if (wdt_pend_r) begin
        take    = 1'b1;
        cause   = `CAUSE_WDT;
        sel_vec = `VEC_WDT;
      end else if (osc_pend_r) begin
        take    = 1'b1;
        cause   = `CAUSE_OSC;
        sel_vec = `VEC_WDT;
      end else if (match_hit) begin
        take    = 1'b1;
        cause   = `CAUSE_MATCH;
        sel_vec = `VEC_MATCH;
      end else if (instr_op == `OP_UNDEF) begin
        take    = 1'b1;
        cause   = `CAUSE_UNDEF;
        sel_vec = `VEC_UNDEF;
      end else if (instr_op == `OP_BREAK) begin
        take    = 1'b1;
        cause   = `CAUSE_BREAK;
        sel_vec = `VEC_BREAK;
      end else if (instr_op == `OP_INTO && flag_register[`FLAG_O]) begin
        take    = 1'b1;
        cause   = `CAUSE_OVF;
        sel_vec = `VEC_OVF;
      end else if (instr_op == `OP_INT) begin
        take    = 1'b1;
        cause   = `CAUSE_INT;
        sel_vec = intb_base + {16'h0000, int_num, 2'b00};
        clr_u   = (int_num < `SW_NUM_SPLIT);
      end else if (instr_op == `OP_FAST_RET) begin
        take    = 1'b1;
        cause   = `CAUSE_FRET;
      end else if (per_req && flag_register[`FLAG_I] && (per_level > ipl)) begin
        take    = 1'b1;
        ack     = 1'b1;
        if (fast_sel && per_level == `LEVEL_FAST) begin
          cause = `CAUSE_FAST;
        end else begin
          cause   = `CAUSE_PER;
          sel_vec = intb_base + {16'h0000, per_num, 2'b00};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take) begin
          if (cause == `CAUSE_FAST) begin
            st_nxt = ST_FENT;
          end else if (cause == `CAUSE_FRET) begin
            st_nxt = ST_FRET;
          end else begin
            st_nxt = ST_PUSH;
          end
        end
      end
      ST_PUSH: st_nxt = ST_LOAD;
      ST_LOAD: st_nxt = ST_IDLE;
      ST_FENT: begin
        if (cnt_r == 3'h0) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_FRET: begin
        if (cnt_r == 3'h0) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r              <= ST_IDLE;
      cnt_r             <= 3'h0;
      push_flags_r      <= 16'h0000;
      push_pc_r         <= 24'h000000;
      vec_addr_r        <= 24'h000000;
      pc_value_r        <= 24'h000000;
      flag_value_r      <= 16'h0000;
      saved_flags_reg_r <= 16'h0000;
      saved_pc_reg_r    <= 24'h000000;
      fast_active_r     <= 1'b0;
      last_cause_r      <= `CAUSE_NONE;
    end else begin
      st_r <= st_nxt;
      if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
      if (take) begin
        last_cause_r <= cause;
        flag_value_r <= flag_register & ~(16'h0001 << `FLAG_I) & ~({15'h0000, clr_u} << `FLAG_U);
        case (cause)
          `CAUSE_FAST: begin
            saved_flags_reg_r <= flag_register;
            saved_pc_reg_r    <= pc_cur;
            pc_value_r        <= fast_vector_reg_r;
            fast_active_r     <= 1'b1;
            cnt_r             <= `FAST_ENTRY_CYC - 3'h2;
          end
          `CAUSE_FRET: begin
            pc_value_r    <= saved_pc_reg_r;
            flag_value_r  <= saved_flags_reg_r;
            fast_active_r <= 1'b0;
            cnt_r         <= `FAST_RET_CYC - 3'h2;
          end
          default: begin
            push_flags_r <= flag_register;
            push_pc_r    <= pc_cur;
            vec_addr_r   <= sel_vec;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // event capture; a new event wins over the clear on acceptance
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev_r  <= 1'b1;
      nmi_pend_r  <= 1'b0;
      wdt_pend_r  <= 1'b0;
      osc_pend_r  <= 1'b0;
      match_arm_r <= 1'b1;
    end else begin
      nmi_prev_r <= nmi_pin_b;
      nmi_pend_r <= nmi_fall | (nmi_pend_r & ~(take && cause == `CAUSE_NMI));
      wdt_pend_r <= wdt_underflow | (wdt_pend_r & ~(take && cause == `CAUSE_WDT));
      osc_pend_r <= osc_stop_det | (osc_pend_r & ~(take && cause == `CAUSE_OSC));
      // one match per visit, otherwise the returning instruction re-traps forever
      if (take && cause == `CAUSE_MATCH) begin
        match_arm_r <= 1'b0;
      end else if (instr_valid && !core_hold) begin
        match_arm_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r             <= `CTRL_RST;
      match_enable_reg_r <= `MATCH_EN_RST;
      fast_vector_reg_r  <= `FAST_VEC_RST;
      rdata_r            <= 32'h00000000;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `OFS_CTRL:     ctrl_r             <= reg_wdata[1:0];
          `OFS_MATCH_EN: match_enable_reg_r <= reg_wdata[7:0];
          `OFS_FAST_VEC: fast_vector_reg_r  <= reg_wdata[23:0];
          default:       ctrl_r             <= ctrl_r;
        endcase
      end
      rdata_r <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `OFS_CTRL:        rd_mux = {30'h00000000, ctrl_r};
      `OFS_MATCH_EN:    rd_mux = {24'h000000, match_enable_reg_r};
      `OFS_FAST_VEC:    rd_mux = {8'h00, fast_vector_reg_r};
      `OFS_SAVED_FLAGS: rd_mux = {16'h0000, saved_flags_reg_r};
      `OFS_SAVED_PC:    rd_mux = {8'h00, saved_pc_reg_r};
      `OFS_STATUS:      rd_mux = {16'h0000, last_cause_r, fast_active_r, match_arm_r, osc_pend_r,
                                  wdt_pend_r, nmi_pend_r, 2'b00, st_r};
      default: begin
        if (reg_addr >= `OFS_MATCH_BASE && reg_addr <= `OFS_MATCH_LAST && reg_addr[1:0] == 2'b00) begin
          rd_mux = {8'h00, match_addr[reg_addr[4:2]]};
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rdata         = rdata_r;
  assign core_hold         = ~idle | take;
  assign per_ack           = ack;
  assign push_req          = (st_r == ST_PUSH);
  assign push_flags        = push_flags_r;
  assign push_pc           = push_pc_r;
  assign vec_fetch         = (st_r == ST_LOAD);
  assign vec_addr          = vec_addr_r;
  assign pc_load           = (st_r == ST_FENT || st_r == ST_FRET) && (cnt_r == 3'h0);
  assign pc_value          = pc_value_r;
  assign flag_load         = pc_load | (st_r == ST_LOAD);
  assign flag_value        = flag_value_r;
  assign fast_active       = fast_active_r;
  // save registers double as channel two/three state while the fast path is enabled
  assign xfer_ch23_blocked = fast_sel;

endmodule // interrupt_entry

// ### sim/interrupt_entry_monitor.sv
`include "exc_entry_defines.vh"
module interrupt_entry_monitor (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        instr_valid,
  input wire [2:0]  instr_op,
  input wire [5:0]  int_num,
  input wire [15:0] flag_register,
  input wire [23:0] pc_cur,
  input wire [23:0] intb_base,
  input wire        per_req,
  input wire [2:0]  per_level,
  input wire        per_ack,
  input wire        nmi_pin_b,
  input wire        wdt_underflow,
  input wire        osc_stop_det,
  input wire        core_hold,
  input wire        push_req,
  input wire [15:0] push_flags,
  input wire [23:0] push_pc,
  input wire        vec_fetch,
  input wire [23:0] vec_addr,
  input wire        pc_load,
  input wire        flag_load,
  input wire [15:0] flag_value,
  input wire        xfer_ch23_blocked
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_push_then_vec: assert property (push_req |=> vec_fetch && flag_load && !flag_value[`FLAG_I])
    else $error("vector fetch missing after push");
  a_push_saves_ctx: assert property (push_req |-> push_flags == $past(flag_register) && push_pc == $past(pc_cur))
    else $error("pushed context differs from core state");
  a_call_stack_sel: assert property (vec_fetch && $past(instr_valid, 2) && $past(instr_op, 2) == `OP_INT
    |-> vec_addr == $past(intb_base, 2) + {$past(int_num, 2), 2'b00}
        && flag_value[`FLAG_U] == ($past(int_num, 2) < `SW_NUM_SPLIT ? 1'b0 : $past(flag_register[`FLAG_U], 2)))
    else $error("vector call address or stack select wrong");
  a_per_isp_sel: assert property (per_ack && !(per_level == `LEVEL_FAST && xfer_ch23_blocked)
    |-> ##2 (vec_fetch && !flag_value[`FLAG_U])) else $error("peripheral entry kept user stack");
  a_mask_gates_req: assert property (per_req && !flag_register[`FLAG_I] |-> !per_ack)
    else $error("masked request acknowledged");
  a_ack_one_cycle: assert property (per_ack |=> !per_ack) else $error("acknowledge longer than one cycle");
  a_ovf_quiet: assert property (!$past(core_hold) && instr_valid && instr_op == `OP_INTO
    && !flag_register[`FLAG_O] && !per_req && nmi_pin_b && !wdt_underflow && !osc_stop_det |-> !core_hold)
    else $error("overflow trap taken with flag clear");
  a_fast_entry_len: assert property (per_ack && per_level == `LEVEL_FAST && xfer_ch23_blocked
    |-> core_hold [*4] ##1 (pc_load && flag_load)) else $error("fast entry not five cycles");
  a_fast_ret_len: assert property ($rose(core_hold) && instr_valid && instr_op == `OP_FAST_RET
    |=> !pc_load ##1 (pc_load && flag_load)) else $error("fast return not three cycles");

  c_fast_entry: cover property (per_ack && per_level == `LEVEL_FAST && xfer_ch23_blocked);
  c_nmi_entry: cover property (vec_fetch && vec_addr == `VEC_NMI);
  c_high_call: cover property (push_req && $past(int_num) >= `SW_NUM_SPLIT);
endmodule // interrupt_entry_monitor

bind interrupt_entry interrupt_entry_monitor mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .instr_valid(instr_valid), .instr_op(instr_op), .int_num(int_num),
  .flag_register(flag_register), .pc_cur(pc_cur), .intb_base(intb_base), .per_req(per_req),
  .per_level(per_level), .per_ack(per_ack), .nmi_pin_b(nmi_pin_b), .wdt_underflow(wdt_underflow),
  .osc_stop_det(osc_stop_det), .core_hold(core_hold), .push_req(push_req), .push_flags(push_flags),
  .push_pc(push_pc), .vec_fetch(vec_fetch), .vec_addr(vec_addr), .pc_load(pc_load), .flag_load(flag_load),
  .flag_value(flag_value), .xfer_ch23_blocked(xfer_ch23_blocked));

// ### sim/core_model.sv
module core_model (
  input  wire         clk_sys,
  input  wire         rst_b,
  input  wire         set_en,
  input  wire  [15:0] set_flags,
  input  wire  [23:0] set_pc,
  input  wire         vec_fetch,
  input  wire  [23:0] vec_addr,
  input  wire         pc_load,
  input  wire  [23:0] pc_value,
  input  wire         flag_load,
  input  wire  [15:0] flag_value,
  output logic [15:0] flag_register,
  output logic [23:0] pc_cur
);
  timeunit 1ns;
  timeprecision 1ps;
  // no debug break or single-step path exists in this core
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_register <= 16'h0000;
      pc_cur <= 24'h000000;
    end else if (set_en) begin
      flag_register <= set_flags;
      pc_cur <= set_pc;
    end else begin
      if (flag_load)
        flag_register <= flag_value;
      // table contents stand in as the inverted vector address
      if (vec_fetch)
        pc_cur <= ~vec_addr;
      else if (pc_load)
        pc_cur <= pc_value;
    end
  end
endmodule // core_model

// ### sim/interrupt_entry_tb.sv
`include "exc_entry_defines.vh"
module interrupt_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] DEF_PC = 24'h001000;
  logic        clk_sys, rst_b, reg_wr, reg_rd, instr_valid, per_req, nmi_pin_b, wdt_underflow, osc_stop_det;
  logic        set_en, per_ack, core_hold, push_req, vec_fetch, pc_load, flag_load, fast_active, xfer_ch23_blocked;
  logic        rd_pend = 1'b0;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [23:0] instr_addr, intb_base, pc_cur, push_pc, vec_addr, pc_value, set_pc, a;
  logic [15:0] flag_register, push_flags, flag_value, set_flags;
  logic [2:0]  instr_op, per_level;
  logic [5:0]  int_num, per_num;
  logic [23:0] exp_q[$];
  logic [31:0] rd_q[$];
  int          bad_count, checked, n;

  interrupt_entry uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr_addr(instr_addr),
    .instr_op(instr_op), .int_num(int_num), .flag_register(flag_register), .pc_cur(pc_cur),
    .intb_base(intb_base), .per_req(per_req), .per_level(per_level), .per_num(per_num), .per_ack(per_ack),
    .nmi_pin_b(nmi_pin_b), .wdt_underflow(wdt_underflow), .osc_stop_det(osc_stop_det), .core_hold(core_hold),
    .push_req(push_req), .push_flags(push_flags), .push_pc(push_pc), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .pc_load(pc_load), .pc_value(pc_value), .flag_load(flag_load), .flag_value(flag_value),
    .fast_active(fast_active), .xfer_ch23_blocked(xfer_ch23_blocked));
  core_model core (.clk_sys(clk_sys), .rst_b(rst_b), .set_en(set_en), .set_flags(set_flags), .set_pc(set_pc),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value), .flag_load(flag_load),
    .flag_value(flag_value), .flag_register(flag_register), .pc_cur(pc_cur));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [23:0] pop_exp();
    return exp_q.size() ? exp_q.pop_front() : 24'hxxxxxx;
  endfunction
  // ----------------------------------------------------------------
  // result watcher: any entry not noted beforehand is a mismatch
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rd_pend)
      check(reg_rdata, rd_q.pop_front());
    rd_pend <= reg_rd;
    if (vec_fetch)
      check(32'(vec_addr), 32'(pop_exp()));
    if (pc_load)
      check(32'(pc_value), 32'(pop_exp()));
  end

  task reg_wr_t(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {ad, d, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task reg_rd_t(input logic [7:0] ad, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {ad, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
  endtask
  task wait_idle;
    int k;
    k = 0;
    repeat (2) @(posedge clk_sys);
    while (core_hold !== 1'b0 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 20) bad_count++;
    @(posedge clk_sys);
  endtask
  task flags_t(input logic [15:0] f, input logic [23:0] p);
    @(posedge clk_sys) {set_en, set_flags, set_pc} <= {1'b1, f, p};
    @(posedge clk_sys) set_en <= 1'b0;
  endtask
  // debug break is never issued from here
  task instr_t(input logic [2:0] op, input logic [5:0] nm, input logic [23:0] ad);
    @(posedge clk_sys) {instr_op, int_num, instr_addr} <= {op, nm, ad};
    @(posedge clk_sys) {instr_op, instr_addr} <= {`OP_NONE, DEF_PC};
    wait_idle;
  endtask
  task per_t(input logic [2:0] lvl, input logic [5:0] nm, input logic ack);
    int k;
    k = 0;
    @(posedge clk_sys) {per_req, per_level, per_num} <= {1'b1, lvl, nm};
    do begin
      @(posedge clk_sys);
      k++;
    end while (per_ack !== 1'b1 && k < 8);
    check(32'(k < 8), 32'(ack));
    per_req <= 1'b0;
    wait_idle;
  endtask
  // event sources: 0 pin falls, 1 watchdog, 2 oscillator stop
  task evt(input int k);
    @(posedge clk_sys) {osc_stop_det, wdt_underflow, nmi_pin_b} <= k == 0 ? 3'h0 : k == 1 ? 3'h3 : 3'h5;
    @(posedge clk_sys) {osc_stop_det, wdt_underflow, nmi_pin_b} <= 3'h1;
    wait_idle;
  endtask
  task finish_test;
    if (exp_q.size() != 0) bad_count++;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    finish_test;
  end

  initial begin
    {reg_wr, reg_rd, per_req, wdt_underflow, osc_stop_det, set_en, rst_b} = '0;
    {nmi_pin_b, instr_valid, instr_op, instr_addr} = {2'b11, `OP_NONE, DEF_PC};
    {reg_addr, reg_wdata, int_num, per_level, per_num, set_flags, set_pc} = '0;
    n = $urandom(32'hcf82);
    intb_base = $urandom & 24'h00FFFC;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    reg_rd_t(`OFS_CTRL, 32'h0);
    reg_rd_t(`OFS_MATCH_EN, 32'h0);
    reg_rd_t(`OFS_FAST_VEC, 32'h0);
    reg_rd_t(8'h18, 32'h0);
    flags_t(16'h0044, DEF_PC);
    exp_q.push_back(`VEC_UNDEF);
    instr_t(`OP_UNDEF, 6'h0, DEF_PC);
    exp_q.push_back(`VEC_BREAK);
    instr_t(`OP_BREAK, 6'h0, DEF_PC);
    exp_q.push_back(`VEC_OVF);
    instr_t(`OP_INTO, 6'h0, DEF_PC);
    flags_t(16'h0040, DEF_PC);
    instr_t(`OP_INTO, 6'h0, DEF_PC);
    for (int i = 0; i < 8; i++) begin
      n = i < 4 ? i[1] * 32 + i[0] * 31 : $urandom_range(63);
      flags_t(16'h00C0, DEF_PC);
      exp_q.push_back(intb_base + 24'(n * 4));
      instr_t(`OP_INT, 6'(n), DEF_PC);
    end
    flags_t(16'h0000, DEF_PC);
    per_t(3'h5, 6'd12, 1'b0);
    flags_t(16'h3040, DEF_PC);
    per_t(3'h3, 6'd9, 1'b0);
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(48, 8);
      flags_t(16'h1040, DEF_PC);
      exp_q.push_back(intb_base + 24'(n * 4));
      per_t(3'($urandom_range(6, 2)), 6'(n), 1'b1);
      exp_q.push_back(intb_base + 24'(n * 4));
      instr_t(`OP_INT, 6'(n), DEF_PC);
    end
    flags_t(16'h0000, DEF_PC);
    exp_q.push_back(`VEC_NMI);
    evt(0);
    exp_q.push_back(`VEC_WDT);
    evt(1);
    exp_q.push_back(`VEC_WDT);
    evt(2);
    for (int i = 0; i < 8; i++) begin
      a = {4'h2, 20'($urandom)};
      reg_wr_t(`OFS_MATCH_BASE + 8'(4 * i), {8'h00, a});
      reg_wr_t(`OFS_MATCH_EN, 32'(1 << i));
      reg_rd_t(`OFS_MATCH_BASE + 8'(4 * i), {8'h00, a});
      exp_q.push_back(`VEC_MATCH);
      instr_t(`OP_NONE, 6'h0, a);
      instr_t(`OP_NONE, 6'h0, a + 24'h1);
    end
    reg_wr_t(`OFS_MATCH_EN, 32'h0);
    instr_t(`OP_NONE, 6'h0, a);
    // dma level-7 bit left clear, a single source at level 7
    a = $urandom & 24'hFFFFFE;
    reg_wr_t(`OFS_CTRL, 32'h1);
    reg_wr_t(`OFS_FAST_VEC, {8'h00, a});
    flags_t(16'h2040, 24'h00ABCE);
    check(32'(xfer_ch23_blocked), 32'h1);
    exp_q.push_back(a);
    per_t(`LEVEL_FAST, 6'd20, 1'b1);
    check(32'(fast_active), 32'h1);
    reg_rd_t(`OFS_SAVED_FLAGS, 32'h2040);
    reg_rd_t(`OFS_SAVED_PC, 32'h00ABCE);
    exp_q.push_back(24'h00ABCE);
    instr_t(`OP_FAST_RET, 6'h0, DEF_PC);
    check(32'(flag_register), 32'h2040);
    reg_rd_t(`OFS_STATUS, 32'h0000B401);
    finish_test;
  end
endmodule // interrupt_entry_tb
